// >>> logic/fifo_map.vh
// Constants for the dual-clock FIFO read port, offset programming and flag logic
`ifndef FIFO_MAP_VH
`define FIFO_MAP_VH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define DATA_W      18
`define ADDR_W      13
`define PTR_W       14
`define OFF_W       13
`define PIN_W       28

// ---------------------------------------------------------------
// Capacities
// ---------------------------------------------------------------
`define DEPTH       14'h2000
`define CAP_STD     14'h2000
`define CAP_FALL_THROUGH_MODE    14'h2001

// ---------------------------------------------------------------
// Offset defaults and serial sequence
// ---------------------------------------------------------------
`define OFF_LOW     13'h007F
`define OFF_HIGH    13'h03FF
`define SER_LAST    5'h19
`define SER_ZERO    5'h00

// ---------------------------------------------------------------
// Reset values and pointer increment
// ---------------------------------------------------------------
`define Q_RESET     18'h0_0000
`define PTR_RESET   14'h0000
`define SYNC_RESET  15'h0000
`define PIN_RESET   28'h000_0000
`define PTR_ONE     14'h0001

// ---------------------------------------------------------------
// Positions in the sampled pin vector, and the overflow bit of the synchronised read pointer
// ---------------------------------------------------------------
`define P_WCLK      27
`define P_RCLK      26
`define P_WEN       25
`define P_REN       24
`define P_LD        23
`define P_SEN       22
`define P_SI        21
`define P_OE        20
`define P_MRS       19
`define P_PRS       18
`define P_D_HI      17
`define P_D_LO      0
`define P_OV        14

`endif

// >>> logic/fifo_read_flags.v
// Read port, output control, offset programming and status flags of a dual-clock FIFO
`timescale 1ns/100ps
//
// Contract
// R1 - Read enable low and data present: next word moves to output register each read edge.
// R2 - Read enable high: output register holds its word.
// R3 - Standard mode: every word needs read enable; empty flag falls after last; reads ignored.
// R4 - Standard mode: empty flag rises two read edges after a write into empty buffer.
// R5 - Fall-through: first word reaches outputs on third read edge after write, unrequested.
// R6 - Fall-through: output-ready rises on a true read after last word; last word stays.
// R7 - Fall-through: output-ready falls with first valid word, stays low through final shift.
// R8 - Serial method, serial enable and load low: one serial bit per write edge.
// R9 - Serial enable high keeps offsets; same behaviour in both modes.
// R10 - Output enable low drives output register; high floats data bus.
// R11 - Load low at master reset: offsets 07F, parallel; high: offsets 3FF, serial.
// R12 - Offsets written only by method chosen at reset, read only in parallel.
// R13 - Controller drives load low to start serial load, parallel load or read.
// R14 - Standard mode: full flag low when full, after depth writes, blocks writes.
// R15 - Fall-through: input-ready high when full counting output word, after depth+1 writes.
// R16 - Full/input-ready updated on write edges, two register stages.
// R17 - Empty/output-ready on read edges, two stages standard, three fall-through.
// R18 - Almost-full low within m words of full, depth or depth+1 based.
// R19 - Almost-full updated only on write edges.
// R20 - Almost-empty low at n or fewer words, n+1 in fall-through.
// R21 - Almost-empty updated only on read edges.
// R22 - Mode pin at master reset: low standard, high fall-through.
// R23 - Partial reset clears pointers and output register, keeps offsets, method, mode.
// R24 - Write enable low and not full stores word each write edge; ignored when full.
// R25 - Loading fills almost-empty offset then almost-full; serial bits LSB first.
// R26 - Pointers cross between domains so each flag changes in its own domain.
`include "fifo_map.vh"

module fifo_read_flags (
    // Clock and reset
    input  wire                core_clk_i,
    input  wire                srst_i,
    // Write side pins
    input  wire                write_clk_i,
    input  wire                write_en_n_i,
    input  wire [`DATA_W-1:0]  data_in_i,
    // Read side pins
    input  wire                read_clk_i,
    input  wire                read_en_n_i,
    input  wire                output_en_n_i,
    // Programming and reset pins
    input  wire                offset_load_n_i,
    input  wire                serial_load_enable_n_i,
    input  wire                mode_select_serial_in_i,
    input  wire                master_reset_n_i,
    input  wire                partial_reset_n_i,
    // Data outputs
    output reg  [`DATA_W-1:0]  data_out_o,
    output reg                 data_out_oe_o,
    // Flags
    output reg                 full_flag_n_o,
    output reg                 empty_flag_n_o,
    output reg                 almost_full_flag_n_o,
    output reg                 almost_empty_flag_n_o
);

    // ---------------------------------------------------------------
    // Pin sampling
    // ---------------------------------------------------------------
    reg  [`PIN_W-1:0]    s1_r;
    reg  [`PIN_W-1:0]    s2_r;
    reg  [`PIN_W-1:0]    s3_r;
    reg  [`PIN_W-1:0]    stb_r;
    reg                  wclk_prev_r;
    reg                  rclk_prev_r;
    wire [`PIN_W-1:0]    pins;

    assign pins = {write_clk_i, read_clk_i, write_en_n_i, read_en_n_i, offset_load_n_i,
                   serial_load_enable_n_i, mode_select_serial_in_i, output_en_n_i,
                   master_reset_n_i, partial_reset_n_i, data_in_i};

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            s1_r        <= `PIN_RESET;
            s2_r        <= `PIN_RESET;
            s3_r        <= `PIN_RESET;
            stb_r       <= `PIN_RESET;
            wclk_prev_r <= 1'b0;
            rclk_prev_r <= 1'b0;
        end else begin
            s1_r        <= pins;
            s2_r        <= s1_r;
            s3_r        <= s2_r;
            stb_r       <= (s2_r & s3_r) | (stb_r & (s2_r | s3_r));
            wclk_prev_r <= stb_r[`P_WCLK];
            rclk_prev_r <= stb_r[`P_RCLK];
        end
    end

    wire                 wclk_ev  = stb_r[`P_WCLK] & ~wclk_prev_r;
    wire                 rclk_ev  = stb_r[`P_RCLK] & ~rclk_prev_r;
    wire                 wen_n    = stb_r[`P_WEN];
    wire                 ren_n    = stb_r[`P_REN];
    wire                 ld_n     = stb_r[`P_LD];
    wire                 sen_n    = stb_r[`P_SEN];
    wire                 si       = stb_r[`P_SI];
    wire                 oe_n     = stb_r[`P_OE];
    wire                 mrs_act  = ~stb_r[`P_MRS];
    wire                 prs_act  = ~stb_r[`P_PRS];
    wire [`DATA_W-1:0]   din      = stb_r[`P_D_HI:`P_D_LO];
    wire                 rst_ptr  = srst_i | mrs_act | prs_act;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function [`PTR_W-1:0] count;
        input [`PTR_W-1:0] head;
        input [`PTR_W-1:0] tail;
        begin
            count = head - tail;
        end
    endfunction

    // ---------------------------------------------------------------
    // Mode, method and offset registers
    // ---------------------------------------------------------------
    reg                  fall_through_mode_r;
    reg                  ser_r;
    reg  [2*`OFF_W-1:0]  off_r;
    reg  [4:0]           ser_cnt_r;
    reg                  pld_sel_r;
    wire [`OFF_W-1:0]    ae_off   = off_r[`OFF_W-1:0];
    wire [`OFF_W-1:0]    af_off   = off_r[2*`OFF_W-1:`OFF_W];
    wire                 fw_sel   = mrs_act ? si : fall_through_mode_r;

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            fall_through_mode_r    <= 1'b0;
            ser_r     <= 1'b0;
            off_r     <= {`OFF_LOW, `OFF_LOW};
            ser_cnt_r <= `SER_ZERO;
            pld_sel_r <= 1'b0;
        end else if (mrs_act) begin
            fall_through_mode_r    <= si;                                   // R22
            ser_r     <= ld_n;                                 // R11
            off_r     <= ld_n ? {`OFF_HIGH, `OFF_HIGH} : {`OFF_LOW, `OFF_LOW}; // R11
            ser_cnt_r <= `SER_ZERO;
            pld_sel_r <= 1'b0;
        end else if (ld_n) begin
            ser_cnt_r <= `SER_ZERO;                            // R13
            pld_sel_r <= 1'b0;
        end else if (wclk_ev) begin
            if (ser_r) begin
                if (!sen_n) begin                              // R8 R9 R12
                    off_r[ser_cnt_r] <= si;                    // R25
                    if (ser_cnt_r == `SER_LAST) begin
                        ser_cnt_r <= `SER_ZERO;
                    end else begin
                        ser_cnt_r <= ser_cnt_r + 5'h01;
                    end
                end
            end else if (!wen_n) begin                         // R12
                if (pld_sel_r) begin
                    off_r[2*`OFF_W-1:`OFF_W] <= din[`OFF_W-1:0];
                end else begin
                    off_r[`OFF_W-1:0] <= din[`OFF_W-1:0];      // R25
                end
                pld_sel_r <= ~pld_sel_r;
            end
        end
    end

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg  [`DATA_W-1:0]   mem [0:`DEPTH-1];

    // ---------------------------------------------------------------
    // Write domain
    // ---------------------------------------------------------------
    reg  [`PTR_W-1:0]    wptr_r;
    reg  [`PTR_W-1:0]    rptr_r;
    reg                  ov_r;
    reg  [`PTR_W:0]      rps1_r;
    reg  [`PTR_W:0]      rps2_r;
    reg                  full_s1_r;
    wire [`PTR_W-1:0]    ret_w    = rps2_r[`PTR_W-1:0] - {{(`PTR_W-1){1'b0}}, rps2_r[`P_OV]};
    wire [`PTR_W-1:0]    cap      = fall_through_mode_r ? `CAP_FALL_THROUGH_MODE : `CAP_STD;
    wire [`PTR_W-1:0]    tot_now  = count(wptr_r, ret_w);
    wire [`PTR_W-1:0]    mem_now  = count(wptr_r, rps2_r[`PTR_W-1:0]);
    wire                 wr_block = (tot_now >= cap) | (mem_now >= `DEPTH);
    wire                 wr_go    = ~rst_ptr & wclk_ev & ld_n & ~wen_n & ~wr_block;
    wire [`PTR_W-1:0]    wptr_nxt = wr_go ? wptr_r + `PTR_ONE : wptr_r;
    wire [`PTR_W-1:0]    tot_nxt  = count(wptr_nxt, ret_w);
    wire [`PTR_W-1:0]    af_lim   = cap - {1'b0, af_off};

    always @(posedge core_clk_i) begin
        if (wr_go) begin
            mem[wptr_r[`ADDR_W-1:0]] <= din;                   // R24
        end
    end

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            wptr_r               <= `PTR_RESET;
            rps1_r               <= `SYNC_RESET;
            rps2_r               <= `SYNC_RESET;
            full_s1_r            <= 1'b0;
            full_flag_n_o        <= 1'b1;
            almost_full_flag_n_o <= 1'b1;
        end else if (mrs_act | prs_act) begin
            wptr_r               <= `PTR_RESET;                // R23
            rps1_r               <= `SYNC_RESET;
            rps2_r               <= `SYNC_RESET;
            full_s1_r            <= 1'b0;
            full_flag_n_o        <= ~fw_sel;
            almost_full_flag_n_o <= 1'b1;
        end else if (wclk_ev) begin
            wptr_r               <= wptr_nxt;                  // R24
            rps1_r               <= {ov_r, rptr_r};            // R26
            rps2_r               <= rps1_r;
            full_s1_r            <= tot_nxt >= cap;            // R14 R15 R16
            full_flag_n_o        <= fall_through_mode_r ? full_s1_r : ~full_s1_r; // R16
            almost_full_flag_n_o <= ~(tot_nxt >= af_lim);      // R18 R19
        end
    end

    // ---------------------------------------------------------------
    // Read domain
    // ---------------------------------------------------------------
    reg  [`PTR_W-1:0]    ws1_r;
    reg  [`PTR_W-1:0]    ws2_r;
    reg  [`PTR_W-1:0]    ws3_r;
    reg                  prd_sel_r;
    // The flag register itself is the last stage, so the compare taps one stage early
    wire [`PTR_W-1:0]    wsrc     = fall_through_mode_r ? ws2_r : ws1_r;   // R4 R5 R17
    wire                 mem_ne   = wsrc != rptr_r;
    wire                 rd_load  = mem_ne & (fall_through_mode_r ? (~ov_r | ~ren_n) : ~ren_n);
    wire [`PTR_W-1:0]    rptr_nxt = rd_load ? rptr_r + `PTR_ONE : rptr_r;
    wire                 ov_nxt   = fall_through_mode_r & (rd_load | (ov_r & ren_n));
    wire [`PTR_W-1:0]    avail    = count(wsrc, rptr_nxt - {{(`PTR_W-1){1'b0}}, ov_nxt});
    wire [`PTR_W-1:0]    ae_lim   = {1'b0, ae_off} + {{(`PTR_W-1){1'b0}}, fall_through_mode_r};

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            rptr_r                <= `PTR_RESET;
            ov_r                  <= 1'b0;
            ws1_r                 <= `PTR_RESET;
            ws2_r                 <= `PTR_RESET;
            ws3_r                 <= `PTR_RESET;
            prd_sel_r             <= 1'b0;
            data_out_o            <= `Q_RESET;
            empty_flag_n_o        <= 1'b0;
            almost_empty_flag_n_o <= 1'b0;
        end else if (mrs_act | prs_act) begin
            rptr_r                <= `PTR_RESET;               // R23
            ov_r                  <= 1'b0;
            ws1_r                 <= `PTR_RESET;
            ws2_r                 <= `PTR_RESET;
            ws3_r                 <= `PTR_RESET;
            prd_sel_r             <= 1'b0;
            data_out_o            <= `Q_RESET;                 // R23
            empty_flag_n_o        <= fw_sel;
            almost_empty_flag_n_o <= 1'b0;
        end else begin
            if (ld_n) begin
                prd_sel_r <= 1'b0;
            end
            if (rclk_ev) begin
                ws1_r <= wptr_r;                               // R26
                ws2_r <= ws1_r;
                ws3_r <= ws2_r;
                if (!ld_n) begin
                    if (!ren_n) begin                          // R12
                        data_out_o <= {{(`DATA_W-`OFF_W){1'b0}},
                                       prd_sel_r ? af_off : ae_off};
                        prd_sel_r  <= ~prd_sel_r;
                    end
                end else begin
                    rptr_r <= rptr_nxt;                        // R3
                    ov_r   <= ov_nxt;                          // R6
                    if (rd_load) begin
                        data_out_o <= mem[rptr_r[`ADDR_W-1:0]]; // R1 R2 R5
                    end
                    if (fall_through_mode_r) begin
                        empty_flag_n_o <= ~ov_nxt;             // R6 R7 R17
                    end else begin
                        empty_flag_n_o <= wsrc != rptr_nxt;    // R3 R4 R17
                    end
                    almost_empty_flag_n_o <= avail > ae_lim;   // R20 R21
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Output enable
    // ---------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            data_out_oe_o <= 1'b0;
        end else begin
            data_out_oe_o <= ~oe_n;                            // R10
        end
    end

endmodule

// >>> verif/fifo_read_flags_assertions.sv
// Port checker for the FIFO read port, output enable and flags
`timescale 1ns/100ps
`include "fifo_map.vh"
module fifo_read_flags_assertions (
    input wire               core_clk_i,
    input wire               srst_i,
    input wire               write_clk_i,
    input wire               read_clk_i,
    input wire               output_en_n_i,
    input wire               mode_select_serial_in_i,
    input wire               master_reset_n_i,
    input wire               partial_reset_n_i,
    input wire [`DATA_W-1:0] data_out_o,
    input wire               data_out_oe_o,
    input wire               full_flag_n_o,
    input wire               empty_flag_n_o,
    input wire               almost_full_flag_n_o,
    input wire               almost_empty_flag_n_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    sequence rd_quiet;
        (!read_clk_i && master_reset_n_i && partial_reset_n_i)[*8];
    endsequence
    sequence wr_quiet;
        (!write_clk_i && master_reset_n_i && partial_reset_n_i)[*8];
    endsequence
    sequence oe_steady;
        $stable(output_en_n_i)[*8];
    endsequence
    rd_idle_hold_a: assert property (rd_quiet |=> $stable(data_out_o))
        else $error("data out changed without read edge");
    rd_flags_hold_a: assert property (rd_quiet |=> $stable(empty_flag_n_o)
        && $stable(almost_empty_flag_n_o))
        else $error("read side flag changed without read edge");
    wr_flags_hold_a: assert property (wr_quiet |=> $stable(full_flag_n_o)
        && $stable(almost_full_flag_n_o))
        else $error("write side flag changed without write edge");
    oe_drive_a: assert property (oe_steady ##0 !output_en_n_i |-> data_out_oe_o)
        else $error("data bus not driven");
    oe_float_a: assert property (oe_steady ##0 output_en_n_i |-> !data_out_oe_o)
        else $error("data bus not floated");
    reset_state_a: assert property ($fell(srst_i) |-> full_flag_n_o && !empty_flag_n_o
        && almost_full_flag_n_o && !almost_empty_flag_n_o && data_out_o == `Q_RESET)
        else $error("wrong state after reset");
    mrs_mode_a: assert property ((!master_reset_n_i && $stable(mode_select_serial_in_i))[*8]
        |-> full_flag_n_o == !mode_select_serial_in_i
        && empty_flag_n_o == mode_select_serial_in_i && data_out_o == `Q_RESET)
        else $error("master reset flags wrong");
    prs_clear_a: assert property ((!partial_reset_n_i && master_reset_n_i)[*8]
        |-> data_out_o == `Q_RESET && !almost_empty_flag_n_o && almost_full_flag_n_o)
        else $error("partial reset state wrong");
endmodule
bind fifo_read_flags fifo_read_flags_assertions chk_i (.core_clk_i, .srst_i, .write_clk_i,
    .read_clk_i, .output_en_n_i, .mode_select_serial_in_i, .master_reset_n_i,
    .partial_reset_n_i, .data_out_o, .data_out_oe_o, .full_flag_n_o, .empty_flag_n_o,
    .almost_full_flag_n_o, .almost_empty_flag_n_o);

// >>> verif/fifo_side_model.sv
// Writer and reader clock source standing at the far side of the FIFO
`timescale 1ns/100ps
module fifo_side_model (
    // Clock
    input  wire core_clk_i,
    // Requests
    input  wire wr_go_i,
    input  wire rd_go_i,
    // Pin clocks
    output wire write_clk_o,
    output wire read_clk_o
);
    reg [2:0] wcnt_r = 3'h0;
    reg [2:0] rcnt_r = 3'h0;
    // One four-cycle pulse per request, low otherwise
    always @(posedge core_clk_i) begin
        if (wr_go_i) begin
            wcnt_r <= 3'h4;
        end else if (wcnt_r != 3'h0) begin
            wcnt_r <= wcnt_r - 3'h1;
        end
        if (rd_go_i) begin
            rcnt_r <= 3'h4;
        end else if (rcnt_r != 3'h0) begin
            rcnt_r <= rcnt_r - 3'h1;
        end
    end
    assign write_clk_o = (wcnt_r != 3'h0);
    assign read_clk_o  = (rcnt_r != 3'h0);
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the FIFO read port, offsets and flags
`timescale 1ns/100ps
`include "fifo_map.vh"
module testbench;
    reg                core_clk = 1'b0;
    reg                srst = 1'b1;
    reg                wgo = 1'b0;
    reg                rgo = 1'b0;
    reg                wen_n = 1'b1;
    reg                ren_n = 1'b1;
    reg                oe_n = 1'b0;
    reg                ld_n = 1'b1;
    reg                sen_n = 1'b1;
    reg                msi = 1'b0;
    reg                mrs_n = 1'b1;
    reg                prs_n = 1'b1;
    reg  [`DATA_W-1:0] din = `Q_RESET;
    wire               wclk;
    wire               rclk;
    wire [`DATA_W-1:0] dout;
    wire               oe;
    wire               ff_n;
    wire               ef_n;
    wire               af_n;
    wire               ae_n;
    integer            n_mismatch = 0;
    integer            cmp_count = 0;
    integer            i;
    initial forever #20 core_clk = ~core_clk;
    fifo_side_model side (.core_clk_i(core_clk), .wr_go_i(wgo), .rd_go_i(rgo),
        .write_clk_o(wclk), .read_clk_o(rclk));
    fifo_read_flags uut (.core_clk_i(core_clk), .srst_i(srst), .write_clk_i(wclk),
        .write_en_n_i(wen_n), .data_in_i(din), .read_clk_i(rclk), .read_en_n_i(ren_n),
        .output_en_n_i(oe_n), .offset_load_n_i(ld_n), .serial_load_enable_n_i(sen_n),
        .mode_select_serial_in_i(msi), .master_reset_n_i(mrs_n), .partial_reset_n_i(prs_n),
        .data_out_o(dout), .data_out_oe_o(oe), .full_flag_n_o(ff_n), .empty_flag_n_o(ef_n),
        .almost_full_flag_n_o(af_n), .almost_empty_flag_n_o(ae_n));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task chk(input [8*6:1] nm, input [`DATA_W-1:0] e, input [`DATA_W-1:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task chkf(input [8*6:1] nm, input e, input g);
        chk(nm, {17'h0_0000, e}, {17'h0_0000, g});
    endtask
    task wedge(input [`DATA_W-1:0] d, input en);
        din <= d;
        wen_n <= en;
        wgo <= 1'b1;
        @(posedge core_clk) wgo <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
    task redge(input en);
        ren_n <= en;
        rgo <= 1'b1;
        @(posedge core_clk) rgo <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
    task mreset(input mode, input ld);
        mrs_n <= 1'b0;
        msi <= mode;
        ld_n <= ld;
        repeat (10) @(posedge core_clk);
        mrs_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        ld_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    task rdoff(input [12:0] n, input [12:0] m);
        ld_n <= 1'b0;
        redge(1'b0);
        chk("ae_off", {5'h00, n}, dout);
        redge(1'b0);
        chk("af_off", {5'h00, m}, dout);
        ld_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_std;
        mreset(1'b0, 1'b0);
        chkf("ef_n", 1'b0, ef_n);
        wedge(18'h1_1111, 1'b0);
        wedge(18'h2_2222, 1'b0);
        redge(1'b1);
        chkf("ef_n", 1'b0, ef_n);
        redge(1'b1);
        chkf("ef_n", 1'b1, ef_n);
        chk("dout", `Q_RESET, dout);
        redge(1'b0);
        chk("dout", 18'h1_1111, dout);
        redge(1'b1);
        chk("dout", 18'h1_1111, dout);
        redge(1'b0);
        chkf("ef_n", 1'b0, ef_n);
        redge(1'b0);
        chk("dout", 18'h2_2222, dout);
    endtask
    task t_ae;
        for (i = 0; i < 127; i = i + 1)
            wedge(18'h0_0100, 1'b0);
        repeat (3) redge(1'b1);
        chkf("ae_n", 1'b0, ae_n);
        wedge(18'h0_0100, 1'b0);
        chkf("ae_n", 1'b0, ae_n);
        repeat (3) redge(1'b1);
        chkf("ae_n", 1'b1, ae_n);
    endtask
    task t_par;
        ld_n <= 1'b0;
        wedge(18'h0_0002, 1'b0);
        wedge(18'h0_0005, 1'b0);
        ld_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        prs_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        prs_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("dout", `Q_RESET, dout);
        chkf("ef_n", 1'b0, ef_n);
        rdoff(13'h0002, 13'h0005);
    endtask
    task t_ser;
        mreset(1'b0, 1'b1);
        ld_n <= 1'b0;
        wedge(18'h0_0011, 1'b0);
        ld_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdoff(13'h03FF, 13'h03FF);
        ld_n <= 1'b0;
        for (i = 0; i < 26; i = i + 1) begin
            if (i == 6) begin
                sen_n <= 1'b1;
                msi <= 1'b1;
                wedge(`Q_RESET, 1'b1);
            end
            sen_n <= 1'b0;
            msi <= (i == 0 || i == 1 || i == 13 || i == 16);
            wedge(`Q_RESET, 1'b1);
        end
        sen_n <= 1'b1;
        ld_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdoff(13'h0003, 13'h0009);
    endtask
    task t_fall_through_mode;
        mreset(1'b1, 1'b1);
        chkf("ir_n", 1'b0, ff_n);
        chkf("or_n", 1'b1, ef_n);
        wedge(18'h0_AAAA, 1'b0);
        wedge(18'h1_5555, 1'b0);
        repeat (2) redge(1'b1);
        chk("dout", `Q_RESET, dout);
        redge(1'b1);
        chk("dout", 18'h0_AAAA, dout);
        chkf("or_n", 1'b0, ef_n);
        redge(1'b0);
        chk("dout", 18'h1_5555, dout);
        chkf("or_n", 1'b0, ef_n);
        redge(1'b0);
        chkf("or_n", 1'b1, ef_n);
        chk("dout", 18'h1_5555, dout);
    endtask
    task t_oe;
        oe_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        chkf("oe", 1'b0, oe);
        oe_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        chkf("oe", 1'b1, oe);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_std;
        t_ae;
        t_par;
        t_ser;
        t_fall_through_mode;
        t_oe;
        close_out;
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch = n_mismatch + 1;
        close_out;
    end
endmodule
